// ### design/me_seq_pkg.sv
// Constants, register map and state encodings of the transition sequencer.
// Behaviour
// - Two independent wipe systems, each may take either complex pattern generator.
// - Six pattern generators: two complex plus the keyer generators, also for masks.
// - Black interlude is two transitions, into and out of black, one trigger each.
// - While in the black interlude the whole output picture is black.
// - Program blackout fade ramps program output to black at a preset rate.
// - Cut acts at once; mix and wipe follow preset rate or lever.
// - Main transition has one rate and lever; four keyers own rates and triggers.
// - On completion with background selected, buses A and B swap selections; A stays on air.
// - Next stack is current stack with selected keys toggled, plus selected background and priority.
// - Preview always shows the next stack composite.
// - Transitions blend whole current composite into whole next composite.
// - Key opacity stays full during a stack transition, except for a keyer running its own fade.
// - Keyer trigger fades that keyer opacity alone, outside the composite.
// - Keys layer by priority, top first, backgrounds beneath all keys.
// - A priority change can ride in a transition, keys stay fully keyed.
// - Keyer takes background, cut and fill; fill may be matte; self key.
package me_seq_pkg;
   localparam int          ADDR_W         = 8;
   localparam int          NUM_KEYS       = 4;
   localparam int          NUM_COMPLEX    = 2;
   localparam int          NUM_WIPE_GEN   = 6;
   localparam logic [7:0]  PROG_MAX       = 8'hFF;
   localparam logic [7:0]  PROG_MIN       = 8'h00;
   localparam logic [7:0]  STEP_MIN       = 8'h01;
   // Register byte offsets.
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_CMD        = 8'h04;
   localparam logic [7:0]  REG_MRATE      = 8'h08;
   localparam logic [7:0]  REG_KRATE      = 8'h0C;
   localparam logic [7:0]  REG_FRATE      = 8'h10;
   localparam logic [7:0]  REG_BUS        = 8'h14;
   localparam logic [7:0]  REG_NEXT       = 8'h18;
   localparam logic [7:0]  REG_KCFG       = 8'h1C;
   localparam logic [7:0]  REG_STAT       = 8'h20;
   localparam logic [7:0]  REG_STACK      = 8'h24;
   localparam logic [7:0]  REG_OPAC       = 8'h28;
   // Writable bit masks and reset values.
   localparam logic [31:0] CTRL_MASK      = 32'h0000007F;
   localparam logic [31:0] RATE_MASK      = 32'h000000FF;
   localparam logic [31:0] NEXT_MASK      = 32'h0000FF3F;
   localparam logic [31:0] KCFG_MASK      = 32'h00007777;
   localparam logic [31:0] RST_RATE       = 32'h00000010;
   localparam logic [31:0] RST_KRATE      = 32'h10101010;
   localparam logic [31:0] RST_NEXT       = 32'h0000E400;
   localparam logic [7:0]  RST_ORDER      = 8'hE4;
   localparam logic [7:0]  RST_BUS_A      = 8'h00;
   localparam logic [7:0]  RST_BUS_B      = 8'h01;
   // Field positions.
   localparam int          CTRL_KIND      = 0;
   localparam int          CTRL_MANUAL    = 2;
   localparam int          CTRL_WSYS      = 3;
   localparam int          CTRL_BLACK     = 4;
   localparam int          CTRL_GEN0      = 5;
   localparam int          CMD_MAIN       = 0;
   localparam int          CMD_FTB        = 1;
   localparam int          CMD_KEY        = 4;
   localparam int          NEXT_BG        = 4;
   localparam int          NEXT_PRI       = 5;
   localparam int          NEXT_ORDER     = 8;
   localparam int          KCFG_MATTE     = 0;
   localparam int          KCFG_SELF      = 1;
   localparam int          KCFG_PAT       = 2;
   localparam logic [1:0]  KIND_CUT       = 2'b00;
   localparam logic [1:0]  KIND_WIPE      = 2'b10;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_HOLD = 2'b10} main_state_e;
   typedef enum logic [1:0] {BLK_NONE = 2'b00, BLK_INTO = 2'b01, BLK_OUT = 2'b10} black_half_e;
endpackage

// ### design/me_transition_sequencer.sv
// Transition sequencer of one mix/effects stage with its AXI4-Lite register file.
`timescale 1ns/1ps
module me_transition_sequencer
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Video timing and panel
   input  wire logic        field_tick,
   input  wire logic [7:0]  lever_pos,
   // Background buses and mixer
   output logic [7:0]       bus_a_src,
   output logic [7:0]       bus_b_src,
   output logic [7:0]       mix_progress,
   output logic [1:0]       trans_kind,
   output logic             trans_active,
   output logic             trans_done,
   output logic             incoming_black,
   output logic             outgoing_black,
   output logic             black_force,
   output logic             wipe_sys_sel,
   output logic [1:0]       wipe_sys_gen,
   output logic [5:0]       gen_in_use,
   // Stacks and preview
   output logic [3:0]       cur_keys_on,
   output logic [7:0]       cur_priority,
   output logic [3:0]       next_keys_on,
   output logic [7:0]       next_priority,
   output logic [7:0]       preview_bg_src,
   // Keyers and program fade
   output logic [31:0]      key_opacity,
   output logic [3:0]       key_self,
   output logic [3:0]       key_fill_matte,
   output logic [7:0]       program_blackout_fade_level
);

   function automatic logic [7:0] ramp(input logic [7:0] v, input logic [7:0] r,
                                       input logic up);
      logic [7:0] st;
      logic [8:0] s;
      st = (r == me_seq_pkg::PROG_MIN) ? me_seq_pkg::STEP_MIN : r;
      s  = up ? ({1'b0, v} + {1'b0, st}) : ({1'b0, v} - {1'b0, st});
      if (s[8])
         return up ? me_seq_pkg::PROG_MAX : me_seq_pkg::PROG_MIN;
      return s[7:0];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++)
         if (st[b])
            r[8*b +: 8] = n[8*b +: 8];
      return r;
   endfunction

   logic                    aw_got;
   logic                    w_got;
   logic [7:0]              wa;
   logic [31:0]             wd;
   logic [3:0]              ws;
   logic [31:0]             ctrl;
   logic [31:0]             mrate;
   logic [31:0]             krate;
   logic [31:0]             frate;
   logic [31:0]             next_sel;
   logic [31:0]             kcfg;
   logic [31:0]             rd_val;
   logic                    rd_ok;
   logic                    wr_ok;
   logic [7:0]              lever_m;
   logic [7:0]              lever_s;
   logic [7:0]              lever_last;
   me_seq_pkg::main_state_e state;
   me_seq_pkg::black_half_e blk;
   me_seq_pkg::black_half_e blk_next;
   logic [7:0]              progress;
   logic                    ftb_busy;
   logic                    ftb_dark;
   logic [3:0]              kbusy;
   logic [3:0]              kdone;
   logic [3:0]              key_pat;

   assign s_axi_awready = !aw_got;
   assign s_axi_wready  = !w_got;
   assign s_axi_arready = !s_axi_rvalid;
   wire wr_go = aw_got && w_got && !s_axi_bvalid;

   // A write lands one cycle after both halves are held; a pending response blocks the next.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         wa           <= 8'h00;
         wd           <= 32'h00000000;
         ws           <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= me_seq_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got <= 1'b1;
            wa     <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got <= 1'b1;
            wd    <= s_axi_wdata;
            ws    <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? me_seq_pkg::RESP_OKAY : me_seq_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   assign wr_ok = (wa[1:0] == 2'b00) && (wa <= me_seq_pkg::REG_OPAC);
   wire cmd_wr   = wr_go && (wa == me_seq_pkg::REG_CMD) && ws[0];
   wire cmd_main = cmd_wr && wd[me_seq_pkg::CMD_MAIN];
   wire cmd_ftb  = cmd_wr && wd[me_seq_pkg::CMD_FTB];
   wire [3:0] key_go = cmd_wr ? wd[me_seq_pkg::CMD_KEY +: 4] : 4'h0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl     <= 32'h00000000;
         mrate    <= me_seq_pkg::RST_RATE;
         krate    <= me_seq_pkg::RST_KRATE;
         frate    <= me_seq_pkg::RST_RATE;
         next_sel <= me_seq_pkg::RST_NEXT;
         kcfg     <= 32'h00000000;
      end
      else if (wr_go)
      begin
         case (wa)
            me_seq_pkg::REG_CTRL:  ctrl     <= merge(ctrl, wd, ws) & me_seq_pkg::CTRL_MASK;
            me_seq_pkg::REG_MRATE: mrate    <= merge(mrate, wd, ws) & me_seq_pkg::RATE_MASK;
            me_seq_pkg::REG_KRATE: krate    <= merge(krate, wd, ws);
            me_seq_pkg::REG_FRATE: frate    <= merge(frate, wd, ws) & me_seq_pkg::RATE_MASK;
            me_seq_pkg::REG_NEXT:  next_sel <= merge(next_sel, wd, ws) & me_seq_pkg::NEXT_MASK;
            me_seq_pkg::REG_KCFG:  kcfg     <= merge(kcfg, wd, ws) & me_seq_pkg::KCFG_MASK;
            default:               ctrl     <= ctrl;
         endcase
      end
   end

   always_comb
   begin
      rd_ok  = 1'b1;
      rd_val = 32'h00000000;
      case (s_axi_araddr)
         me_seq_pkg::REG_CTRL:  rd_val = ctrl;
         me_seq_pkg::REG_CMD:   rd_val = 32'h00000000;
         me_seq_pkg::REG_MRATE: rd_val = mrate;
         me_seq_pkg::REG_KRATE: rd_val = krate;
         me_seq_pkg::REG_FRATE: rd_val = frate;
         me_seq_pkg::REG_BUS:   rd_val = {16'h0000, bus_b_src, bus_a_src};
         me_seq_pkg::REG_NEXT:  rd_val = next_sel;
         me_seq_pkg::REG_KCFG:  rd_val = kcfg;
         me_seq_pkg::REG_STAT:  rd_val = {8'h00, program_blackout_fade_level, progress,
                                          kbusy, ftb_dark, ftb_busy, black_force,
                                          trans_active};
         me_seq_pkg::REG_STACK: rd_val = {next_priority, cur_priority, 8'h00,
                                          next_keys_on, cur_keys_on};
         me_seq_pkg::REG_OPAC:  rd_val = key_opacity;
         default:               rd_ok  = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= me_seq_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_ok ? me_seq_pkg::RESP_OKAY : me_seq_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // The lever word is only used at field ticks, long after it has settled, so a plain
   // two-stage sync of all bits is enough here.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lever_m    <= 8'h00;
         lever_s    <= 8'h00;
         lever_last <= 8'h00;
      end
      else
      begin
         lever_m <= lever_pos;
         lever_s <= lever_m;
         if (field_tick)
            lever_last <= lever_s;
      end
   end

   wire manual   = ctrl[me_seq_pkg::CTRL_MANUAL];
   wire is_cut   = trans_kind == me_seq_pkg::KIND_CUT;
   wire lever_go = field_tick && (lever_last == me_seq_pkg::PROG_MIN)
                   && (lever_s != me_seq_pkg::PROG_MIN);
   wire start    = (state != me_seq_pkg::ST_RUN)
                   && (cmd_main || (manual && !is_cut && lever_go));
   wire done_run = (state == me_seq_pkg::ST_RUN) && (progress == me_seq_pkg::PROG_MAX);
   assign blk_next = (state == me_seq_pkg::ST_HOLD) ? me_seq_pkg::BLK_OUT :
                     (ctrl[me_seq_pkg::CTRL_BLACK] ? me_seq_pkg::BLK_INTO : me_seq_pkg::BLK_NONE);
   wire cut_now  = start && is_cut;
   wire end_blk  = (cut_now && blk_next == me_seq_pkg::BLK_INTO)
                   || (done_run && blk == me_seq_pkg::BLK_INTO);
   wire fin      = (cut_now && blk_next != me_seq_pkg::BLK_INTO)
                   || (done_run && blk != me_seq_pkg::BLK_INTO);

   // The first half ends parked in black; only a fresh trigger runs the second half.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state      <= me_seq_pkg::ST_IDLE;
         blk        <= me_seq_pkg::BLK_NONE;
         progress   <= me_seq_pkg::PROG_MIN;
         trans_done <= 1'b0;
      end
      else
      begin
         trans_done <= fin;
         case (state)
            me_seq_pkg::ST_IDLE, me_seq_pkg::ST_HOLD, me_seq_pkg::ST_RUN:
            begin
               if (end_blk)
               begin
                  state    <= me_seq_pkg::ST_HOLD;
                  blk      <= me_seq_pkg::BLK_NONE;
                  progress <= me_seq_pkg::PROG_MIN;
               end
               else if (fin)
               begin
                  state    <= me_seq_pkg::ST_IDLE;
                  blk      <= me_seq_pkg::BLK_NONE;
                  progress <= me_seq_pkg::PROG_MIN;
               end
               else if (start)
               begin
                  state    <= me_seq_pkg::ST_RUN;
                  blk      <= blk_next;
                  progress <= me_seq_pkg::PROG_MIN;
               end
               else if (state == me_seq_pkg::ST_RUN && field_tick)
                  progress <= manual ? lever_s : ramp(progress, mrate[7:0], 1'b1);
            end
            default:
               state <= me_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // Progress blends the whole outgoing composite into the whole incoming one.
   assign mix_progress   = progress;
   assign trans_kind     = ctrl[me_seq_pkg::CTRL_KIND +: 2];
   assign trans_active   = state == me_seq_pkg::ST_RUN;
   assign incoming_black = trans_active && blk == me_seq_pkg::BLK_INTO;
   assign outgoing_black = trans_active && blk == me_seq_pkg::BLK_OUT;
   assign black_force    = state == me_seq_pkg::ST_HOLD;
   assign wipe_sys_sel   = ctrl[me_seq_pkg::CTRL_WSYS];
   assign wipe_sys_gen   = ctrl[me_seq_pkg::CTRL_GEN0 +: me_seq_pkg::NUM_COMPLEX];
   wire wipe_on = trans_active && trans_kind == me_seq_pkg::KIND_WIPE;
   wire gen_pick = wipe_sys_gen[wipe_sys_sel];
   assign gen_in_use = {key_pat, wipe_on && gen_pick, wipe_on && !gen_pick};

   // Swap happens on the same edge that ends the transition, so the output never glitches.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bus_a_src <= me_seq_pkg::RST_BUS_A;
         bus_b_src <= me_seq_pkg::RST_BUS_B;
      end
      else if (fin && next_sel[me_seq_pkg::NEXT_BG])
      begin
         bus_a_src <= bus_b_src;
         bus_b_src <= bus_a_src;
      end
      else if (wr_go && wa == me_seq_pkg::REG_BUS)
      begin
         if (ws[0])
            bus_a_src <= wd[7:0];
         if (ws[1])
            bus_b_src <= wd[15:8];
      end
   end

   wire [3:0] next_keys_c = cur_keys_on ^ next_sel[3:0];
   wire [7:0] next_pri_c  = next_sel[me_seq_pkg::NEXT_PRI] ?
                            next_sel[me_seq_pkg::NEXT_ORDER +: 8] : cur_priority;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cur_keys_on    <= 4'h0;
         cur_priority   <= me_seq_pkg::RST_ORDER;
         next_keys_on   <= 4'h0;
         next_priority  <= me_seq_pkg::RST_ORDER;
         preview_bg_src <= me_seq_pkg::RST_BUS_A;
      end
      else
      begin
         cur_keys_on    <= (fin ? next_keys_c : cur_keys_on) ^ kdone;
         next_keys_on   <= next_keys_c;
         next_priority  <= next_pri_c;
         preview_bg_src <= next_sel[me_seq_pkg::NEXT_BG] ? bus_b_src : bus_a_src;
         if (fin)
            cur_priority <= next_pri_c;
      end
   end

   // Each keyer ramps its own opacity; outside its own fade a keyer stays fully opaque.
   for (genvar k = 0; k < me_seq_pkg::NUM_KEYS; k++)
   begin : g_key
      logic       busy;
      logic       up;
      logic [7:0] lvl;
      wire        at_end = up ? (lvl == me_seq_pkg::PROG_MAX) : (lvl == me_seq_pkg::PROG_MIN);
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            busy <= 1'b0;
            up   <= 1'b0;
            lvl  <= me_seq_pkg::PROG_MIN;
         end
         else if (!busy && key_go[k])
         begin
            busy <= 1'b1;
            up   <= !cur_keys_on[k];
            lvl  <= cur_keys_on[k] ? me_seq_pkg::PROG_MAX : me_seq_pkg::PROG_MIN;
         end
         else if (busy && at_end)
            busy <= 1'b0;
         else if (busy && field_tick)
            lvl <= ramp(lvl, krate[8*k +: 8], up);
      end
      assign kbusy[k]          = busy;
      assign kdone[k]          = busy && at_end;
      assign key_opacity[8*k +: 8] = busy ? lvl : me_seq_pkg::PROG_MAX;
      assign key_self[k]       = kcfg[4*k + me_seq_pkg::KCFG_SELF];
      assign key_fill_matte[k] = kcfg[4*k + me_seq_pkg::KCFG_MATTE];
      assign key_pat[k]        = kcfg[4*k + me_seq_pkg::KCFG_PAT];
   end

   wire ftb_end = ftb_dark ? (program_blackout_fade_level == me_seq_pkg::PROG_MAX)
                           : (program_blackout_fade_level == me_seq_pkg::PROG_MIN);

   // Each trigger reverses the fade direction; a trigger mid-fade is ignored.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ftb_busy                    <= 1'b0;
         ftb_dark                    <= 1'b0;
         program_blackout_fade_level <= me_seq_pkg::PROG_MIN;
      end
      else if (!ftb_busy && cmd_ftb)
      begin
         ftb_busy <= 1'b1;
         ftb_dark <= !ftb_dark;
      end
      else if (ftb_busy && ftb_end)
         ftb_busy <= 1'b0;
      else if (ftb_busy && field_tick)
         program_blackout_fade_level <= ramp(program_blackout_fade_level, frate[7:0],
                                             ftb_dark);
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_cut_swap: assert property (cut_now && blk_next != me_seq_pkg::BLK_INTO
      && next_sel[me_seq_pkg::NEXT_BG] |=> bus_a_src == $past(bus_b_src)
      && bus_b_src == $past(bus_a_src) && state == me_seq_pkg::ST_IDLE)
      else $error("cut did not swap buses at once");
   a_run_swap: assert property (done_run && blk != me_seq_pkg::BLK_INTO
      && next_sel[me_seq_pkg::NEXT_BG] |=> bus_a_src == $past(bus_b_src) && trans_done)
      else $error("buses not swapped at completion");
   a_black_half: assert property (done_run && blk == me_seq_pkg::BLK_INTO
      |=> black_force && bus_a_src == $past(bus_a_src) && !trans_done)
      else $error("first black half did not park in black");
   a_black_hold: assert property (black_force && !start |=> black_force)
      else $error("black left without a trigger");
   a_prog_rate: assert property (trans_active && field_tick && !manual && !done_run
      |=> progress == ramp($past(progress), $past(mrate[7:0]), 1'b1))
      else $error("progress did not advance by rate");
   a_lever_track: assert property (trans_active && field_tick && manual && !done_run
      |=> progress == $past(lever_s))
      else $error("progress does not follow lever");
   a_ftb_ramp: assert property (ftb_busy && ftb_dark && field_tick && !ftb_end
      |=> program_blackout_fade_level > $past(program_blackout_fade_level))
      else $error("blackout fade not rising");
   a_key_opaque: assert property (trans_active && kbusy == 4'h0
      |-> key_opacity == {me_seq_pkg::NUM_KEYS{me_seq_pkg::PROG_MAX}})
      else $error("key opacity changed during stack transition");
   a_next_stack: assert property (!fin && kdone == 4'h0
      |=> next_keys_on == ($past(cur_keys_on) ^ $past(next_sel[3:0])))
      else $error("next stack wrong");
   a_key_done: assert property (kdone[0] && !fin |=> cur_keys_on[0] != $past(cur_keys_on[0]))
      else $error("keyer fade did not change key state");

   c_cut: cover property (cut_now && next_sel[me_seq_pkg::NEXT_BG]);
   c_black: cover property (black_force ##[1:50] outgoing_black);
   c_ftb: cover property (ftb_dark && ftb_end && !ftb_busy);
   c_key: cover property (kdone[1]);

endmodule // me_transition_sequencer

// ### dv/me_transition_sequencer_test.sv
// Bench of the transition sequencer driven over its register bus.
`timescale 1ns/1ps
module me_transition_sequencer_test;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tick, bk;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp;
   logic [7:0]  awaddr, araddr, lever_req, lever, fade, pv;
   logic [3:0]  ks, km;
   logic [5:0]  gen;
   logic [31:0] wdata, rdata, d;
   int          failures = 0, n_checks = 0, cyc = 0;
   panel_model panel_u (.aclk(aclk), .aresetn(aresetn), .lever_req(lever_req),
      .field_tick(tick), .lever_pos(lever));
   me_transition_sequencer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .field_tick(tick),
      .lever_pos(lever), .bus_a_src(), .bus_b_src(), .mix_progress(), .trans_kind(),
      .trans_active(), .trans_done(), .incoming_black(), .outgoing_black(),
      .black_force(bk), .wipe_sys_sel(), .wipe_sys_gen(), .gen_in_use(gen), .cur_keys_on(),
      .cur_priority(), .next_keys_on(), .next_priority(), .preview_bg_src(pv),
      .key_opacity(), .key_self(ks), .key_fill_matte(km), .program_blackout_fade_level(fade));
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic stop_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // The whole sequence needs a few hundred cycles; a hang ends here.
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         stop_test();
      end
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      {awaddr, wdata} <= {a, v};
      {awvalid, wvalid, bready} <= 3'b111;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      d = {30'h0, bresp};
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rready <= 1'b0;
   endtask
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      do rd(8'h20); while ((d & m) != v);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk($sformatf("register %h", a), e, d & m);
   endtask
   task automatic trig(input logic [31:0] c, input logic [31:0] m, input logic [31:0] v);
      wr(8'h00, c);
      wr(8'h04, 32'h1);
      poll(m, v);
   endtask
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
      {awaddr, araddr, wdata, lever_req} = '0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(8'h14, 32'hFFFF, 32'h0100);
      rc(8'h24, 32'hFFFF0000, 32'hE4E40000);
      wr(8'h18, 32'hE410);
      wr(8'h08, 32'h80);
      chk("preview_bg_src", 32'h1, {24'h0, pv});
      for (int k = 0; k < 3; k++)
      begin
         trig(32'(k), 32'h1, 32'h0);
         rc(8'h14, 32'hFFFF, k[0] ? 32'h0100 : 32'h0001);
      end
      trig(32'h11, 32'h3, 32'h2);
      chk("black_force", 32'h1, {31'h0, bk});
      rc(8'h14, 32'hFFFF, 32'h0001);
      trig(32'h11, 32'h3, 32'h0);
      rc(8'h14, 32'hFFFF, 32'h0100);
      wr(8'h00, 32'h05);
      lever_req <= 8'h80;
      poll(32'hFF01, 32'h8001);
      lever_req <= 8'hFF;
      poll(32'h1, 32'h0);
      lever_req <= 8'h00;
      rc(8'h14, 32'hFFFF, 32'h0001);
      wr(8'h18, 32'h1B21);
      rc(8'h24, 32'hFFFF00FF, 32'h1BE40010);
      trig(32'h1, 32'h1, 32'h0);
      rc(8'h24, 32'hFFFF00FF, 32'h1B1B0001);
      wr(8'h04, 32'h20);
      poll(32'hF0, 32'h0);
      rc(8'h24, 32'hF, 32'h3);
      rc(8'h28, 32'hFFFFFFFF, 32'hFFFFFFFF);
      wr(8'h10, 32'hFF);
      wr(8'h04, 32'h2);
      poll(32'h4, 32'h0);
      chk("fade_level", 32'hFF, {24'h0, fade});
      wr(8'h1C, 32'h16);
      chk("key_self", 32'h1, {28'h0, ks});
      chk("key_fill_matte", 32'h2, {28'h0, km});
      chk("gen_in_use", 32'h4, {26'h0, gen});
      wr(8'h2C, 32'h1);
      chk("bresp", {30'h0, me_seq_pkg::RESP_SLVERR}, d);
      stop_test();
   end
endmodule // me_transition_sequencer_test

// ### dv/panel_model.sv
// Operator panel model: field reference pulses and the lever arm.
`timescale 1ns/1ps
module panel_model
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Lever setting from the bench
   input  wire logic [7:0] lever_req,
   // Field reference and lever
   output logic            field_tick,
   output logic [7:0]      lever_pos
);
   logic [1:0] div;
   // A short field keeps every ramp brief; expectations do not depend on its length.
   always_ff @(posedge aclk)
   begin
      div        <= aresetn ? div + 2'h1 : 2'h0;
      field_tick <= aresetn && div == 2'h3;
      lever_pos  <= lever_req;
   end
endmodule // panel_model
